// ===== design/orx_pkg.sv
package orx_pkg;
    // Operation select codes presented by the core's decoder
    typedef enum logic [3:0] {
        ORX_OP_NONE,
        ORX_OP_OR_MEM,
        ORX_OP_RET,
        ORX_OP_RET_IMM,
        ORX_OP_INTERRUPT_RETURN_OP,
        ORX_OP_RL,
        ORX_OP_RLA,
        ORX_OP_RLC,
        ORX_OP_ROTATE_LEFT_CARRY_TO_ACC_OP,
        ORX_OP_RR,
        ORX_OP_RRA,
        ORX_OP_RRC
    } orx_op_t;

    localparam int ORX_DATA_W = 8;
    localparam int ORX_PC_W = 13;
    localparam int ORX_RET_CYCLES = 2;
    localparam logic [7:0] ORX_ACC_RST = 8'h00;
    localparam logic [12:0] ORX_PC_RST = 13'h0000;
    localparam logic [ORX_PC_W-1:0] ORX_PC_STEP = 13'h0001;
endpackage : orx_pkg

// ===== design/orx_alu_if.sv
`timescale 1ns/1ps
interface orx_alu_if;
    import orx_pkg::*;
    orx_op_t op;
    logic [7:0] mem_val;
    logic [7:0] acc_val;
    logic carry_in;
    logic [7:0] result;
    logic carry_out;
    logic zero;
    modport core (output op, output mem_val, output acc_val, output carry_in,
                  input result, input carry_out, input zero);
    modport alu (input op, input mem_val, input acc_val, input carry_in,
                 output result, output carry_out, output zero);
endinterface : orx_alu_if

// ===== design/orx_alu.sv
`timescale 1ns/1ps
module orx_alu
    import orx_pkg::*;
(
    orx_alu_if.alu alu
);
    always_comb begin
        alu.result = alu.mem_val;
        alu.carry_out = alu.carry_in;
        case (alu.op)
            ORX_OP_OR_MEM: alu.result = alu.acc_val | alu.mem_val;
            ORX_OP_RL, ORX_OP_RLA: alu.result = {alu.mem_val[6:0], alu.mem_val[7]};
            ORX_OP_RLC, ORX_OP_ROTATE_LEFT_CARRY_TO_ACC_OP: begin
                alu.result = {alu.mem_val[6:0], alu.carry_in};
                alu.carry_out = alu.mem_val[7];
            end
            ORX_OP_RR, ORX_OP_RRA: alu.result = {alu.mem_val[0], alu.mem_val[7:1]};
            ORX_OP_RRC: begin
                alu.result = {alu.carry_in, alu.mem_val[7:1]};
                alu.carry_out = alu.mem_val[0];
            end
            default: alu.result = alu.mem_val;
        endcase
        alu.zero = (alu.result == 8'h00);
    end
endmodule : orx_alu

// ===== design/orx_exec.sv
// Behaviour
// - OR accumulator into memory, zero flag only
// - Plain return pops PC, two cycles, no flags
// - Return loads immediate into accumulator, pops PC
// - Interrupt return pops PC, sets master enable
// - Rotate memory left, wrap bit 7
// - Rotate left into accumulator, memory unchanged
// - Rotate left through carry, write memory
// - Rotate left through carry into accumulator
// - Rotate memory right, wrap bit 0
// - Rotate right into accumulator, memory unchanged
`timescale 1ns/1ps
module orx_exec
    import orx_pkg::*;
#(
    parameter int PC_W = ORX_PC_W
)
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Instruction issue
    input wire logic issue_i,
    input wire orx_op_t op_i,
    input wire logic [7:0] imm_i,
    input wire logic [7:0] mem_rd_i,
    input wire logic [PC_W-1:0] stack_top_i,
    input wire logic irq_ack_i,
    // Data memory write
    output logic mem_wr_o,
    output logic [7:0] mem_wd_o,
    // Stack pop
    output logic stack_pop_o,
    // Architectural state
    output logic [7:0] acc_o,
    output logic carry_o,
    output logic zero_o,
    output logic master_irq_enable_o,
    output logic [PC_W-1:0] pc_o,
    output logic busy_o,
    output logic done_o
);
    typedef enum logic [1:0] {ORX_IDLE, ORX_RET_WAIT} orx_state_t;

    typedef struct packed {
        orx_state_t state;
        logic [7:0] acc;
        logic carry;
        logic zero;
        logic irq_en;
        logic [PC_W-1:0] pc;
        logic mem_wr;
        logic [7:0] mem_wd;
        logic pop;
        logic done;
        logic busy;
    } orx_st_t;

    orx_st_t st_reg;
    orx_st_t st_next;
    orx_alu_if alu_bus();

    assign alu_bus.op = op_i;
    assign alu_bus.mem_val = mem_rd_i;
    assign alu_bus.acc_val = st_reg.acc;
    assign alu_bus.carry_in = st_reg.carry;

    orx_alu u_alu (
        .alu(alu_bus.alu)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.mem_wr = 1'b0;
        st_next.pop = 1'b0;
        st_next.done = 1'b0;
        // Interrupt entry clears the enable; a same-cycle interrupt return re-sets it
        if (irq_ack_i) begin
            st_next.irq_en = 1'b0;
        end
        case (st_reg.state)
            ORX_IDLE: begin
                if (issue_i) begin
                    case (op_i)
                        ORX_OP_RET, ORX_OP_RET_IMM, ORX_OP_INTERRUPT_RETURN_OP: begin
                            st_next.pop = 1'b1;
                            st_next.pc = stack_top_i;
                            st_next.state = ORX_RET_WAIT;
                            st_next.busy = 1'b1;
                            if (op_i == ORX_OP_RET_IMM) begin
                                st_next.acc = imm_i;
                            end
                            if (op_i == ORX_OP_INTERRUPT_RETURN_OP) begin
                                st_next.irq_en = 1'b1;
                            end
                        end
                        ORX_OP_OR_MEM: begin
                            st_next.mem_wr = 1'b1;
                            st_next.mem_wd = alu_bus.result;
                            st_next.zero = alu_bus.zero;
                        end
                        ORX_OP_RL, ORX_OP_RR: begin
                            st_next.mem_wr = 1'b1;
                            st_next.mem_wd = alu_bus.result;
                        end
                        ORX_OP_RLA, ORX_OP_RRA: begin
                            st_next.acc = alu_bus.result;
                        end
                        ORX_OP_RLC, ORX_OP_RRC: begin
                            st_next.mem_wr = 1'b1;
                            st_next.mem_wd = alu_bus.result;
                            st_next.carry = alu_bus.carry_out;
                        end
                        ORX_OP_ROTATE_LEFT_CARRY_TO_ACC_OP: begin
                            st_next.acc = alu_bus.result;
                            st_next.carry = alu_bus.carry_out;
                        end
                        default: begin
                        end
                    endcase
                    if (op_i != ORX_OP_RET && op_i != ORX_OP_RET_IMM && op_i != ORX_OP_INTERRUPT_RETURN_OP) begin
                        st_next.pc = st_reg.pc + PC_W'(ORX_PC_STEP);
                        st_next.done = 1'b1;
                    end
                end
            end
            ORX_RET_WAIT: begin
                // Second cycle of a return; no issue accepted here
                st_next.state = ORX_IDLE;
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
            default: begin
                st_next.state = ORX_IDLE;
                st_next.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '{state: ORX_IDLE, acc: ORX_ACC_RST, carry: 1'b0, zero: 1'b0, irq_en: 1'b0,
                        pc: PC_W'(ORX_PC_RST), mem_wr: 1'b0, mem_wd: 8'h00, pop: 1'b0, done: 1'b0,
                        busy: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign mem_wr_o = st_reg.mem_wr;
    assign mem_wd_o = st_reg.mem_wd;
    assign stack_pop_o = st_reg.pop;
    assign acc_o = st_reg.acc;
    assign carry_o = st_reg.carry;
    assign zero_o = st_reg.zero;
    assign master_irq_enable_o = st_reg.irq_en;
    assign pc_o = st_reg.pc;
    // Busy kept as its own flop so the port comes straight from a register
    assign busy_o = st_reg.busy;
    assign done_o = st_reg.done;

    ////////////////////////////////////////////////////////////////////////////
    sequence ret_issue_s;
        issue_i && !busy_o && (op_i == ORX_OP_RET || op_i == ORX_OP_RET_IMM || op_i == ORX_OP_INTERRUPT_RETURN_OP);
    endsequence
    sequence ret_finish_s;
        stack_pop_o && busy_o ##1 done_o && !busy_o;
    endsequence

    or_zero_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_OR_MEM |=> mem_wr_o && mem_wd_o == ($past(acc_o) | $past(mem_rd_i))
        && zero_o == (mem_wd_o == 8'h00) && carry_o == $past(carry_o))
        else $error("or into memory result wrong");
    ret_timing_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ret_issue_s |=> ret_finish_s)
        else $error("return not two cycles");
    ret_flags_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ret_issue_s |=> pc_o == $past(stack_top_i) && carry_o == $past(carry_o) && zero_o == $past(zero_o))
        else $error("return changed flags or pc");
    ret_imm_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_RET_IMM |=> acc_o == $past(imm_i) ##1 acc_o == $past(imm_i, 2))
        else $error("immediate not loaded");
    interrupt_return_op_enable_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_INTERRUPT_RETURN_OP && !irq_ack_i |=> master_irq_enable_o)
        else $error("interrupt return did not enable");
    rl_wrap_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_RL |=> mem_wr_o && mem_wd_o == {$past(mem_rd_i[6:0]), $past(mem_rd_i[7])})
        else $error("rotate left wrong");
    rla_acc_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_RLA |=> !mem_wr_o && acc_o == {$past(mem_rd_i[6:0]), $past(mem_rd_i[7])})
        else $error("rotate left to acc wrong");
    rlc_carry_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_RLC |=> mem_wd_o == {$past(mem_rd_i[6:0]), $past(carry_o)}
        && carry_o == $past(mem_rd_i[7]))
        else $error("rotate left carry wrong");
    rotate_left_carry_to_acc_op_acc_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_ROTATE_LEFT_CARRY_TO_ACC_OP |=> !mem_wr_o && acc_o == {$past(mem_rd_i[6:0]), $past(carry_o)})
        else $error("rotate left carry acc wrong");
    rr_wrap_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_RR |=> mem_wd_o == {$past(mem_rd_i[0]), $past(mem_rd_i[7:1])})
        else $error("rotate right wrong");
    rra_acc_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_RRA |=> acc_o == {$past(mem_rd_i[0]), $past(mem_rd_i[7:1])})
        else $error("rotate right to acc wrong");
    rrc_carry_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i == ORX_OP_RRC |=> mem_wd_o == {$past(carry_o), $past(mem_rd_i[7:1])}
        && carry_o == $past(mem_rd_i[0]))
        else $error("rotate right carry wrong");
    pc_step_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !busy_o && op_i inside {ORX_OP_OR_MEM, ORX_OP_RL, ORX_OP_RLA, ORX_OP_RLC, ORX_OP_ROTATE_LEFT_CARRY_TO_ACC_OP,
        ORX_OP_RR, ORX_OP_RRA, ORX_OP_RRC} |=> done_o && !busy_o && pc_o == $past(pc_o) + PC_W'(1))
        else $error("pc not advanced by one");

    ////////////////////////////////////////////////////////////////////////////
    // Side effects that must not happen; each op leaves the other state alone
    sequence op_issue_s(orx_op_t code);
        issue_i && !busy_o && op_i == code;
    endsequence
    sequence flags_kept_s;
        carry_o == $past(carry_o) && zero_o == $past(zero_o);
    endsequence

    wr_pulse_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        mem_wr_o && !$past(issue_i) |-> !$past(mem_wr_o))
        else $error("memory write longer than one cycle");

    or_acc_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_OR_MEM) |=> acc_o == $past(acc_o) && !stack_pop_o)
        else $error("or into memory touched accumulator");

    pop_pulse_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        stack_pop_o |=> !stack_pop_o)
        else $error("stack pop longer than one cycle");

    ret_nowrite_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_RET) |=> !mem_wr_o && acc_o == $past(acc_o) ##1 !mem_wr_o)
        else $error("plain return wrote state");

    interrupt_return_op_flags_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_INTERRUPT_RETURN_OP) |=> flags_kept_s)
        else $error("interrupt return changed flags");

    rl_flags_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_RL) |=> flags_kept_s)
        else $error("rotate left changed flags");

    rla_flags_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_RLA) |=> flags_kept_s)
        else $error("rotate left to acc changed flags");

    rlc_keep_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_RLC) |=> mem_wr_o && zero_o == $past(zero_o) && acc_o == $past(acc_o))
        else $error("rotate left carry side effect");

    rotate_left_carry_to_acc_op_carry_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_ROTATE_LEFT_CARRY_TO_ACC_OP) |=> carry_o == $past(mem_rd_i[7]) && zero_o == $past(zero_o))
        else $error("rotate left carry acc flag wrong");

    rr_flags_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_RR) |=> mem_wr_o ##0 flags_kept_s)
        else $error("rotate right changed flags");

    rra_flags_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_RRA) |=> !mem_wr_o ##0 flags_kept_s)
        else $error("rotate right to acc side effect");

    rrc_keep_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        op_issue_s(ORX_OP_RRC) |=> mem_wr_o && zero_o == $past(zero_o) && acc_o == $past(acc_o))
        else $error("rotate right carry side effect");

    busy_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        busy_o |=> pc_o == $past(pc_o) && !mem_wr_o && !stack_pop_o)
        else $error("issue taken while busy");
endmodule : orx_exec

// ===== tb/or_return_rotate_exec_tb_top.sv
`timescale 1ns/1ps
module or_return_rotate_exec_tb_top;
    import orx_pkg::*;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic issue_i = 1'b0;
    orx_op_t op_i = ORX_OP_NONE;
    logic [7:0] imm_i = 8'h00;
    logic [7:0] mem_rd_i = 8'h00;
    logic [12:0] stack_top_i = 13'h0000;
    logic irq_ack_i = 1'b0;
    logic mem_wr_o, stack_pop_o, carry_o, zero_o, master_irq_enable_o, busy_o, done_o;
    logic [7:0] mem_wd_o, acc_o;
    logic [12:0] pc_o;
    int error_cnt = 0;
    int checked = 0;
    // Expected architectural state
    logic [7:0] e_acc = 8'h00;
    logic e_c = 1'b0, e_z = 1'b0, e_mie = 1'b0;
    logic [12:0] e_pc = 13'h0000;

    always #4 core_clk_i = ~core_clk_i;

    orx_exec #(.PC_W(ORX_PC_W)) DUT (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .issue_i(issue_i), .op_i(op_i), .imm_i(imm_i),
        .mem_rd_i(mem_rd_i), .stack_top_i(stack_top_i), .irq_ack_i(irq_ack_i), .mem_wr_o(mem_wr_o),
        .mem_wd_o(mem_wd_o), .stack_pop_o(stack_pop_o), .acc_o(acc_o), .carry_o(carry_o),
        .zero_o(zero_o), .master_irq_enable_o(master_irq_enable_o), .pc_o(pc_o), .busy_o(busy_o),
        .done_o(done_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // Issues one op, follows it to done under a bound, then compares all state
    task automatic do_op(input orx_op_t op, input logic [7:0] mem, input logic [7:0] imm, input logic [12:0] stk);
        logic [7:0] wd;
        logic [7:0] seen_wd;
        int cyc, n_wr, n_pop, n_busy, i;
        bit is_ret, e_wr;
        wd = 8'h00;
        is_ret = op inside {ORX_OP_RET, ORX_OP_RET_IMM, ORX_OP_INTERRUPT_RETURN_OP};
        e_wr = op inside {ORX_OP_OR_MEM, ORX_OP_RL, ORX_OP_RLC, ORX_OP_RR, ORX_OP_RRC};
        e_pc = is_ret ? stk : e_pc + ORX_PC_STEP;
        case (op)
            ORX_OP_OR_MEM: begin
                wd = e_acc | mem;
                e_z = (wd == 8'h00);
            end
            ORX_OP_RET_IMM: e_acc = imm;
            ORX_OP_INTERRUPT_RETURN_OP: e_mie = 1'b1;
            ORX_OP_RL: wd = {mem[6:0], mem[7]};
            ORX_OP_RLA: e_acc = {mem[6:0], mem[7]};
            ORX_OP_RLC: begin
                wd = {mem[6:0], e_c};
                e_c = mem[7];
            end
            ORX_OP_ROTATE_LEFT_CARRY_TO_ACC_OP: begin
                e_acc = {mem[6:0], e_c};
                e_c = mem[7];
            end
            ORX_OP_RR: wd = {mem[0], mem[7:1]};
            ORX_OP_RRA: e_acc = {mem[0], mem[7:1]};
            ORX_OP_RRC: begin
                wd = {e_c, mem[7:1]};
                e_c = mem[0];
            end
            default: ;
        endcase
        @(posedge core_clk_i);
        issue_i <= 1'b1;
        op_i <= op;
        mem_rd_i <= mem;
        imm_i <= imm;
        stack_top_i <= stk;
        @(posedge core_clk_i);
        issue_i <= 1'b0;
        {cyc, n_wr, n_pop, n_busy} = '0;
        seen_wd = 8'h00;
        for (i = 1; i <= 4 && cyc == 0; i++) begin
            #1;
            if (mem_wr_o === 1'b1) begin
                n_wr++;
                seen_wd = mem_wd_o;
            end
            n_pop += (stack_pop_o === 1'b1);
            n_busy += (busy_o === 1'b1);
            if (done_o === 1'b1) cyc = i;
            else @(posedge core_clk_i);
        end
        if (cyc == 0) begin
            error_cnt++;
            $display("ERROR done expected 1 seen 0");
            complete_run();
        end
        chk("cycles", is_ret ? 16'h0002 : 16'h0001, 16'(cyc));
        chk("busy", {15'h0000, is_ret}, 16'(n_busy));
        chk("pc", {3'h0, e_pc}, {3'h0, pc_o});
        chk("acc", {8'h00, e_acc}, {8'h00, acc_o});
        chk("flags", {13'h0000, e_c, e_z, e_mie}, {13'h0000, carry_o, zero_o, master_irq_enable_o});
        chk("writes", {15'h0000, e_wr}, 16'(n_wr));
        chk("pops", {15'h0000, is_ret}, 16'(n_pop));
        if (e_wr) chk("wdata", {8'h00, wd}, {8'h00, seen_wd});
    endtask : do_op

    ////////////////////////////////////////////////////////////////////////////////
    task automatic reset_scn();
        chk("reset", 16'h0000, {1'b0, acc_o, carry_o, zero_o, master_irq_enable_o, mem_wr_o, stack_pop_o, busy_o, done_o});
        chk("reset_pc", 16'h0000, {3'h0, pc_o});
    endtask : reset_scn

    task automatic returns_scn();
        do_op(ORX_OP_RET, 8'h3c, 8'h77, 13'h1abc);
        do_op(ORX_OP_RET_IMM, 8'h00, 8'ha5, 13'h0010);
        do_op(ORX_OP_INTERRUPT_RETURN_OP, 8'h00, 8'h11, 13'h1fff);
    endtask : returns_scn

    task automatic irq_ack_scn();
        @(posedge core_clk_i);
        irq_ack_i <= 1'b1;
        @(posedge core_clk_i);
        irq_ack_i <= 1'b0;
        #1;
        e_mie = 1'b0;
        chk("enable", 16'h0000, {15'h0000, master_irq_enable_o});
    endtask : irq_ack_scn

    // Pc wraps from the top address here, and the last OR leaves zero set for the rotates
    task automatic or_scn();
        do_op(ORX_OP_OR_MEM, 8'h5a, 8'h00, 13'h0000);
        do_op(ORX_OP_RET_IMM, 8'h00, 8'h00, 13'h0123);
        do_op(ORX_OP_OR_MEM, 8'h00, 8'h00, 13'h0000);
    endtask : or_scn

    task automatic rot_scn();
        do_op(ORX_OP_RLC, 8'h81, 8'h00, 13'h0000);
        do_op(ORX_OP_RL, 8'h80, 8'h00, 13'h0000);
        do_op(ORX_OP_RR, 8'h01, 8'h00, 13'h0000);
        do_op(ORX_OP_RLA, 8'h96, 8'h00, 13'h0000);
        do_op(ORX_OP_RRA, 8'h69, 8'h00, 13'h0000);
        do_op(ORX_OP_ROTATE_LEFT_CARRY_TO_ACC_OP, 8'h40, 8'h00, 13'h0000);
        do_op(ORX_OP_RRC, 8'h80, 8'h00, 13'h0000);
        do_op(ORX_OP_RRC, 8'h01, 8'h00, 13'h0000);
        do_op(ORX_OP_RET, 8'h00, 8'h00, 13'h0555);
    endtask : rot_scn

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        #1;
        reset_scn();
        returns_scn();
        irq_ack_scn();
        or_scn();
        rot_scn();
        complete_run();
    end
endmodule : or_return_rotate_exec_tb_top
